// >>> hdl/pressure_freq_counter_pwm_dac.sv
// frequency-to-digital converter with serial readout and pwm dac
`include "freq_dac_cfg.svh"
`default_nettype none
module pressure_freq_counter_pwm_dac
   import freq_dac_pkg::*;
#(
   parameter int GATE_CYCLES = `GATE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic osc_in,
   input wire logic ser_clk,
   input wire logic ser_load,
   input wire logic ser_din,
   output logic [1:0] osc_sel,
   output logic data_ready,
   output logic ser_dout,
   output logic pwm_out,
   output logic mcu_clk
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: change counts when stages two and three agree
   logic [2:0] osc_s_r;
   logic [2:0] sck_s_r;
   logic [2:0] ld_s_r;
   logic [2:0] din_s_r;
   logic osc_q_r;
   logic sck_q_r;
   logic ld_q_r;
   logic din_q_r;
   // no reset on the chains: they flush themselves within three clocks
   always_ff @(posedge clk) begin
      osc_s_r <= {osc_s_r[1:0], osc_in};
      sck_s_r <= {sck_s_r[1:0], ser_clk};
      ld_s_r <= {ld_s_r[1:0], ser_load};
      din_s_r <= {din_s_r[1:0], ser_din};
   end

   // filtered level: follows the pin only once two stages agree, so a
   // pulse shorter than a clock never counts as an edge
   function automatic logic filt(input logic [2:0] s, input logic q);
      filt = (s[2] == s[1]) ? s[2] : q;
   endfunction : filt

   // filtered levels; the data pin is filtered too so a bit that changes
   // near a serial clock edge is never taken half-settled
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_q_r <= 1'h0;
         sck_q_r <= 1'h0;
         ld_q_r <= 1'h0;
         din_q_r <= 1'h0;
      end else begin
         osc_q_r <= filt(osc_s_r, osc_q_r);
         sck_q_r <= filt(sck_s_r, sck_q_r);
         ld_q_r <= filt(ld_s_r, ld_q_r);
         din_q_r <= filt(din_s_r, din_q_r);
      end
   end

   // one-clock edge strobes, taken from the level the filter is about to hold
   logic osc_rise;
   logic sck_rise;
   logic ld_rise;
   assign osc_rise = filt(osc_s_r, osc_q_r) & ~osc_q_r;
   assign sck_rise = filt(sck_s_r, sck_q_r) & ~sck_q_r;
   assign ld_rise = filt(ld_s_r, ld_q_r) & ~ld_q_r;

   ////////////////////////////////////////////////////////////////////////
   // microcontroller clock from a free divider; it keeps running in every
   // state so the controller never stalls, and its ratio is fixed at build
   logic [7:0] div_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         div_r <= 8'h00;
         mcu_clk <= 1'h0;
      end else if (div_r == 8'(`MCU_CLK_DIV - 1)) begin
         div_r <= 8'h00;
         mcu_clk <= ~mcu_clk;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // measurement sequencer
   meas_state_t state_r;
   logic [`CNT_W-1:0] time_cnt_r;
   logic [`CNT_W-1:0] cyc_cnt_r;
   logic [`RESULTS_W-1:0] results_r;
   // gate is open long enough once the time count reaches its last clock
   logic gate_done;
   assign gate_done = (time_cnt_r >= `CNT_W'(GATE_CYCLES - 1));

   // measurement starts on an oscillator edge so the time count spans whole cycles
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_SETTLE;
         osc_sel <= `SEL_REF;
         time_cnt_r <= '0;
         cyc_cnt_r <= '0;
         data_ready <= 1'h0;
      end else begin
         unique case (state_r)
            ST_SETTLE: begin
               // counts held at zero so nothing from the last slot leaks in
               time_cnt_r <= '0;
               cyc_cnt_r <= '0;
               if (osc_rise) begin
                  state_r <= ST_MEASURE;
               end
            end
            ST_MEASURE: begin
               time_cnt_r <= time_cnt_r + `CNT_W'(1);
               if (osc_rise) begin
                  cyc_cnt_r <= cyc_cnt_r + `CNT_W'(1);
                  if (gate_done) begin
                     state_r <= ST_STORE;
                  end
               end
            end
            ST_STORE: begin
               // the sense slot closes the round; wrap to the reference for the next
               if (osc_sel == `SEL_SENSE) begin
                  osc_sel <= `SEL_REF;
                  state_r <= ST_READY;
                  data_ready <= 1'h1;
               end else begin
                  osc_sel <= osc_sel + 2'h1;
                  state_r <= ST_SETTLE;
               end
            end
            ST_READY: begin
               // hold results until the controller loads them out
               if (ld_rise) begin
                  data_ready <= 1'h0;
                  state_r <= ST_SETTLE;
               end
            end
         endcase
      end
   end

   // result store: slot picked by the active frequency, ref lowest
   always_ff @(posedge clk) begin
      if (reset) begin
         results_r <= '0;
      end else if (state_r == ST_STORE) begin
         results_r[osc_sel*`RESULT_W +: `RESULT_W] <= {time_cnt_r, cyc_cnt_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial port: load captures results, each ser_clk rise shifts one bit
   logic [`RESULTS_W-1:0] shift_r;
   logic [`DAC_W-1:0] rx_r;
   // transmit: load wins over a shift in the same clock, the controller
   // keeps the two apart anyway
   always_ff @(posedge clk) begin
      if (reset) begin
         shift_r <= '0;
         ser_dout <= 1'h0;
      end else if (ld_rise) begin
         shift_r <= results_r;
         ser_dout <= results_r[`RESULTS_W-1];
      end else if (sck_rise) begin
         shift_r <= {shift_r[`RESULTS_W-2:0], 1'h0};
         ser_dout <= shift_r[`RESULTS_W-2];
      end
   end

   // receive: the filtered data level is taken at each serial clock rise,
   // msb first; only the last sixteen bits survive
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_r <= '0;
      end else if (sck_rise) begin
         rx_r <= {rx_r[`DAC_W-2:0], din_q_r};
      end
   end

   // value taken when load falls, so a write-back is atomic
   logic ld_fall;
   logic [`DAC_W-1:0] dac_val_r;
   assign ld_fall = ~filt(ld_s_r, ld_q_r) & ld_q_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         dac_val_r <= '0;
      end else if (ld_fall) begin
         dac_val_r <= rx_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm: period 2^DAC_W clocks, duty copied only at wrap to avoid glitches
   logic [`DAC_W-1:0] pwm_cnt_r;
   logic [`DAC_W-1:0] duty_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         pwm_cnt_r <= '0;
         duty_r <= '0;
         pwm_out <= 1'h0;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + `DAC_W'(1);
         if (pwm_cnt_r == '1) begin
            duty_r <= dac_val_r;
         end
         // compare against the held duty, never the live value
         pwm_out <= (pwm_cnt_r < duty_r);
      end
   end

endmodule : pressure_freq_counter_pwm_dac
`default_nettype wire

// >>> hdl/freq_dac_cfg.svh
// timing counts, widths and oscillator select codes for the frequency converter
`ifndef FREQ_DAC_CFG_SVH
`define FREQ_DAC_CFG_SVH
`define CLK_PERIOD_NS 40
`define GATE_TIME_US 1000
`define GATE_CYCLES ((`GATE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W 24
`define RESULT_W 48
`define RESULTS_W 144
`define DAC_W 16
`define MCU_CLK_DIV 2
`define SEL_REF 2'h0
`define SEL_SUM 2'h1
`define SEL_SENSE 2'h2
`endif

// >>> hdl/freq_dac_pkg.sv
// types for the frequency converter
`default_nettype none
package freq_dac_pkg;
   typedef enum logic [1:0] {ST_SETTLE, ST_MEASURE, ST_STORE, ST_READY} meas_state_t;
endpackage : freq_dac_pkg
`default_nettype wire

// >>> sim/freq_dac_monitor.sv
// port checker for the converter
`default_nettype none
module freq_dac_monitor #(parameter int GATE_CYCLES = 50) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ser_clk,
   input wire logic ser_load,
   input wire logic [1:0] osc_sel,
   input wire logic data_ready,
   input wire logic ser_dout,
   input wire logic mcu_clk
);
   timeunit 1ns / 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int gc_r;
   // gate length seen from outside, since the counters are hidden
   always_ff @(posedge clk) gc_r <= (reset || $changed(osc_sel)) ? 0 : gc_r + 1;
   //////
   a_sel_range: assert property (osc_sel != 2'h3) else $error("sel");
   a_sel_order: assert property ($changed(osc_sel) |-> osc_sel ==
      ($past(osc_sel) == 2'h2 ? 2'h0 : $past(osc_sel) + 2'h1)) else $error("order");
   a_gate_time: assert property ($changed(osc_sel) |-> gc_r >= GATE_CYCLES)
      else $error("gate");
   a_ready_wrap: assert property ($rose(data_ready) |-> $past(osc_sel) == 2'h2)
      else $error("early");
   a_ready_sel: assert property (data_ready |-> osc_sel == 2'h0) else $error("idle");
   a_ready_hold: assert property (data_ready && !ser_load |=> data_ready)
      else $error("drop");
   a_mcu_div: assert property ($changed(mcu_clk) |=>
      $stable(mcu_clk) ##1 $changed(mcu_clk)) else $error("mcu");
   a_dout_hold: assert property ((!ser_clk && !ser_load) [*8] |-> $stable(ser_dout))
      else $error("dout");
   c_ready: cover property ($rose(data_ready));
   c_sense: cover property (osc_sel == 2'h2);
   c_shift: cover property ($changed(ser_dout));
endmodule : freq_dac_monitor
bind pressure_freq_counter_pwm_dac freq_dac_monitor #(.GATE_CYCLES(GATE_CYCLES)) u_mon (
   .clk(clk),
   .reset(reset),
   .ser_clk(ser_clk),
   .ser_load(ser_load),
   .osc_sel(osc_sel),
   .data_ready(data_ready),
   .ser_dout(ser_dout),
   .mcu_clk(mcu_clk)
);
`default_nettype wire

// >>> sim/osc_model.sv
// sensor oscillator model
`default_nettype none
module osc_model (
   input wire logic [1:0] osc_sel,
   output logic osc_in
);
   timeunit 1ns / 1ps;
   // 260/220/340 ns periods, off the clk grid so edges drift
   // one process drives the pin; the half period follows the select in force
   initial begin
      osc_in = 1'h0;
      forever begin
         #(osc_sel == 2'h0 ? 130 : osc_sel == 2'h1 ? 110 : 170);
         osc_in = ~osc_in;
      end
   end
endmodule : osc_model
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the converter
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
$display("Error %0t bad value", $time); end end
module testbench;
   timeunit 1ns / 1ps;
   logic clk = 1'h0, reset = 1'h1, ser_clk = 1'h0, ser_load = 1'h0, ser_din = 1'h0;
   logic osc_in, data_ready, ser_dout, pwm_out, mcu_clk;
   logic [1:0] osc_sel;
   logic [143:0] res;
   int n_mismatch = 0, tests_run = 0, d, w;
   localparam logic [15:0] DAC = 16'h3A5C;
   // free-running clock
   always #20 clk = ~clk;
   osc_model u_osc_model (.osc_sel(osc_sel), .osc_in(osc_in));
   pressure_freq_counter_pwm_dac #(.GATE_CYCLES(50)) u_pressure_freq_counter_pwm_dac (
      .clk(clk),
      .reset(reset),
      .osc_in(osc_in),
      .ser_clk(ser_clk),
      .ser_load(ser_load),
      .ser_din(ser_din),
      .osc_sel(osc_sel),
      .data_ready(data_ready),
      .ser_dout(ser_dout),
      .pwm_out(pwm_out),
      .mcu_clk(mcu_clk)
   );
   //////
   task automatic stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic t_measure;
      for (w = 0; w < 3000 && data_ready !== 1'h1; w++) @(negedge clk);
      `CHK(data_ready, 1'h1)
      // a round that never completes ends the run here
      if (data_ready !== 1'h1) stop_test();
   endtask : t_measure
   // word out msb first while the duty value goes in
   task automatic t_read;
      @(posedge clk);
      ser_load <= 1'h1;
      repeat (8) @(posedge clk);
      for (int i = 143; i >= 0; i--) begin
         res[i] = ser_dout;
         ser_din <= i < 16 ? DAC[i] : 1'h0;
         repeat (2) begin
            repeat (5) @(posedge clk);
            ser_clk <= ~ser_clk;
         end
      end
      ser_load <= 1'h0;
      for (int s = 0; s < 3; s++) begin
         d = res[48*s+24 +: 24] * 40 - res[48*s +: 24] * (s == 1 ? 220 : s ? 340 : 260);
         `CHK(res[48*s+24 +: 24] > 49 && d < 121 && d > -121, 1'h1)
      end
   endtask : t_read
   task automatic t_pwm;
      for (w = 0; w < 70000 && pwm_out !== 1'h1; w++) @(negedge clk);
      // no pulse within one period plus margin: count it and report at once
      if (pwm_out !== 1'h1) begin
         n_mismatch++;
         $display("Error %0t no pwm pulse", $time);
         stop_test();
      end
      for (d = 0; d < 70000 && pwm_out === 1'h1; d++) @(negedge clk);
      `CHK(d, DAC)
   endtask : t_pwm
   // reset, then the scenarios in order
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'h0;
      t_measure();
      t_read();
      t_pwm();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
